// ---- eba_top.sv ----
// ethernet boot announcer: sequencer, request framer, frame acceptance
`timescale 1ns/1ns
// Summary of operation
// - codes 8,9,a select ethernet boot
// - code 9: port0 boots, port1 forwards
// - code a: port1 boots, port0 forwards
// - switch control word is 0xe0
// - both port macs get fuse mac
// - enable dma, lookup; single mac entry
// - all ports forward; gmii on 0,1
// - boot port an slave, other master
// - wait 25 ms after switch setup
// - init descriptors, then send request
// - send request once, then await frames
// - all frames received: jump to entry
// - pll config stays 0x13
// - serializer tx config 0xb21
// - deserializer rx config 0x89121
// - one sample per four pll cycles
// - dix header broadcast, own mac, ipv4
// - fixed ipv4 header fields
// - udp ports 68 to 9, length 308
// - bootp body with mac at 70..75
// - bad frames silently dropped
module eba_top
   import eba_pkg::*;
#(
   parameter int WAIT_CYC = EBA_WAIT_CYC
) (
   // clock and reset
   input  wire logic             MCLK,
   input  wire logic             SYS_RST,
   // straps and fuse mac
   input  wire logic [3:0]       BOOT_MODE,
   input  wire logic [47:0]      FUSE_MAC,
   // axi4-lite slave
   input  wire logic [7:0]       S_AWADDR,
   input  wire logic             S_AWVALID,
   output logic                  S_AWREADY,
   input  wire logic [31:0]      S_WDATA,
   input  wire logic [3:0]       S_WSTRB,
   input  wire logic             S_WVALID,
   output logic                  S_WREADY,
   output logic [1:0]            S_BRESP,
   output logic                  S_BVALID,
   input  wire logic             S_BREADY,
   input  wire logic [7:0]       S_ARADDR,
   input  wire logic             S_ARVALID,
   output logic                  S_ARREADY,
   output logic [31:0]           S_RDATA,
   output logic [1:0]            S_RRESP,
   output logic                  S_RVALID,
   input  wire logic             S_RREADY,
   // switch and serdes setup
   output eba_sw_cfg_t           SW_CFG,
   output eba_serdes_cfg_t       SERDES_CFG,
   output logic [47:0]           PORT0_SRC_ADDR,
   output logic [47:0]           PORT1_SRC_ADDR,
   output logic                  ALE_CLEAR,
   output logic                  ALE_WRITE,
   output logic [47:0]           ALE_MAC,
   output logic                  DESC_INIT,
   // request frame stream
   output logic [7:0]            TX_DATA,
   output logic                  TX_VALID,
   output logic                  TX_LAST,
   input  wire logic             TX_READY,
   // received frame verdicts
   input  wire logic             RX_FRAME,
   input  wire logic             RX_GOOD,
   input  wire logic [15:0]      RX_MAGIC,
   input  wire logic [7:0]       RX_OPCODE,
   input  wire logic [7:0]       RX_SEQ,
   // completion
   output logic                  BOOT_DONE,
   output logic [31:0]           ENTRY_ADDR
);
   eba_state_t  state_r, state_nxt;
   logic [31:0] cnt_r;
   logic [8:0]  idx_r;
   logic [47:0] mac_r;
   logic [7:0]  seq_r, nfrm_r;
   logic        port_r, start_r, go_r;
   logic [31:0] entry_r;
   logic        aw_r, w_r;
   logic [7:0]  awa_r;
   logic [31:0] wd_r;

   function automatic logic [7:0] mac_byte(input logic [47:0] m,
                                           input logic [8:0] i,
                                           input logic [8:0] f);
      logic [8:0] k;
      k = i - f;
      mac_byte = m[8'(47 - 8 * int'(k)) -: 8];
   endfunction

   // request frame contents, broadcast and mac fields come from logic
   function automatic logic [7:0] frame_byte(input logic [8:0] i,
                                             input logic [47:0] m);
      frame_byte = 8'h00;
      if (i < EBA_SA_FIRST) frame_byte = 8'hff;
      else if (i <= EBA_SA_LAST) frame_byte = mac_byte(m, i, EBA_SA_FIRST);
      else if (i >= EBA_CHA_FIRST && i <= EBA_CHA_LAST)
         frame_byte = mac_byte(m, i, EBA_CHA_FIRST);
      else
         case (i)
            9'd12: frame_byte = 8'h08;
            9'd14: frame_byte = 8'h45;
            9'd16: frame_byte = 8'h01;
            9'd17: frame_byte = 8'h48;
            9'd19: frame_byte = 8'h01;
            9'd22: frame_byte = 8'h10;
            9'd23: frame_byte = 8'h11;
            9'd24: frame_byte = 8'ha9;
            9'd25: frame_byte = 8'ha5;
            9'd35: frame_byte = 8'h44;
            9'd37: frame_byte = 8'h09;
            9'd38: frame_byte = 8'h01;
            9'd39: frame_byte = 8'h34;
            9'd42: frame_byte = 8'h01;
            9'd43: frame_byte = 8'h01;
            9'd44: frame_byte = 8'h06;
            9'd46: frame_byte = 8'h12;
            9'd47: frame_byte = 8'h34;
            9'd48: frame_byte = 8'h56;
            9'd49: frame_byte = 8'h78;
            9'd51: frame_byte = 8'h01;
            default: frame_byte = 8'h00;
         endcase
   endfunction

   // mode decode
   wire is_eth   = (BOOT_MODE == EBA_MODE_ONLY) ||
                   (BOOT_MODE == EBA_MODE_PORT0) ||
                   (BOOT_MODE == EBA_MODE_PORT1);
   wire boot_p1  = (BOOT_MODE == EBA_MODE_PORT1);
   wire tx_fire  = TX_VALID && TX_READY;
   wire last_b   = (idx_r == 9'(EBA_FRAME_LEN - 1));
   wire frm_ok   = RX_FRAME && RX_GOOD && RX_MAGIC == EBA_BT_MAGIC &&
                   RX_OPCODE == EBA_BT_OP && RX_SEQ == seq_r;
   wire all_in   = frm_ok && (seq_r + 8'h01 == nfrm_r);
   wire wr_go    = aw_r && w_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         EBA_IDLE:   if (go_r && is_eth) state_nxt = EBA_SERDES;
         EBA_SERDES: state_nxt = EBA_SWITCH;
         EBA_SWITCH: state_nxt = EBA_ALE;
         EBA_ALE:    state_nxt = EBA_SETTLE;
         EBA_SETTLE: if (cnt_r == 32'(WAIT_CYC - 1))
                        state_nxt = EBA_DESC;
         EBA_DESC:   state_nxt = EBA_SEND;
         EBA_SEND:   if (tx_fire && last_b)
                        state_nxt = EBA_RECV;
         EBA_RECV:   if (all_in) state_nxt = EBA_DONE;
         EBA_DONE:   state_nxt = EBA_DONE;
         default:    state_nxt = EBA_IDLE;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state_r <= EBA_IDLE;
         cnt_r   <= 32'h0;
         idx_r   <= 9'h0;
         seq_r   <= 8'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= (state_r == EBA_SETTLE) ? cnt_r + 32'h1 : 32'h0;
         if (state_r == EBA_SEND && tx_fire) idx_r <= idx_r + 9'h1;
         if (state_r == EBA_RECV && frm_ok) seq_r <= seq_r + 8'h01;
      end
   end

   // catch straps and fuse mac after reset
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         mac_r  <= 48'h0;
         port_r <= 1'b0;
      end else if (state_r == EBA_IDLE) begin
         mac_r  <= FUSE_MAC;
         port_r <= boot_p1;
      end
   end

   // software registers
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         aw_r <= 1'b0;
         w_r <= 1'b0;
         awa_r <= 8'h0;
         wd_r <= 32'h0;
         S_BVALID <= 1'b0;
         S_RVALID <= 1'b0;
         S_RDATA <= 32'h0;
         S_RRESP <= EBA_RESP_OK;
         S_BRESP <= EBA_RESP_OK;
         start_r <= 1'b0;
         go_r <= 1'b0;
         nfrm_r <= 8'h01;
      end else begin
         go_r <= start_r;
         if (S_AWVALID && S_AWREADY) begin
            aw_r <= 1'b1;
            awa_r <= S_AWADDR;
         end
         if (S_WVALID && S_WREADY) begin
            w_r <= 1'b1;
            wd_r <= S_WDATA;
         end
         if (wr_go) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            S_BVALID <= 1'b1;
            S_BRESP <= EBA_RESP_OK;
            if (awa_r == EBA_REG_CTRL) start_r <= wd_r[0];
            else if (awa_r == EBA_REG_NFRM) nfrm_r <= wd_r[7:0];
            else S_BRESP <= EBA_RESP_ERR;
         end else if (S_BVALID && S_BREADY) S_BVALID <= 1'b0;
         if (S_ARVALID && S_ARREADY) begin
            S_RVALID <= 1'b1;
            S_RRESP <= EBA_RESP_OK;
            case (S_ARADDR)
               EBA_REG_CTRL:  S_RDATA <= {31'h0, start_r};
               EBA_REG_STAT:  S_RDATA <= {16'h0, seq_r, 3'h0, port_r,
                                          BOOT_DONE, 3'h0};
               EBA_REG_MACLO: S_RDATA <= mac_r[31:0];
               EBA_REG_MACHI: S_RDATA <= {16'h0, mac_r[47:32]};
               EBA_REG_ENTRY: S_RDATA <= entry_r;
               EBA_REG_NFRM:  S_RDATA <= {24'h0, nfrm_r};
               default: begin
                  S_RDATA <= 32'h0;
                  S_RRESP <= EBA_RESP_ERR;
               end
            endcase
         end else if (S_RVALID && S_RREADY) S_RVALID <= 1'b0;
      end
   end
   assign S_AWREADY = !aw_r && !S_BVALID;
   assign S_WREADY  = !w_r && !S_BVALID;
   assign S_ARREADY = !S_RVALID;

   // entry point is taken from the first word of frame zero
   always_ff @(posedge MCLK) begin
      if (SYS_RST) entry_r <= 32'h0;
      else if (state_r == EBA_RECV && frm_ok && seq_r == 8'h00)
         entry_r <= {RX_MAGIC, RX_OPCODE, RX_SEQ};
   end

   // switch and serdes settings held while booting
   wire cfg_on = (state_r != EBA_IDLE);
   always_comb begin
      SW_CFG = '0;
      SERDES_CFG = '0;
      if (cfg_on) begin
         SERDES_CFG.pll = EBA_PLL_CFG;
         SERDES_CFG.tx  = EBA_TX_CFG;
         SERDES_CFG.rx  = EBA_RX_CFG;
         SERDES_CFG.sample_div = EBA_SER_DIV;
      end
      if (cfg_on && state_r != EBA_SERDES) begin
         SW_CFG.ctrl      = EBA_SW_CTRL;
         SW_CFG.boot_port = port_r;
         SW_CFG.fwd_ports = port_r ? 2'b01 : 2'b10;
         SW_CFG.port_fwd  = 3'b111;
         SW_CFG.gmii_en   = 2'b11;
         SW_CFG.an_master = port_r ? 2'b01 : 2'b10;
         SW_CFG.dma_tx_en = 1'b1;
         SW_CFG.dma_rx_en = 1'b1;
         SW_CFG.ale_en    = 1'b1;
      end
   end
   assign PORT0_SRC_ADDR = mac_r;
   assign PORT1_SRC_ADDR = mac_r;
   assign ALE_CLEAR = (state_r == EBA_SWITCH);
   assign ALE_WRITE = (state_r == EBA_ALE);
   assign ALE_MAC   = mac_r;
   assign DESC_INIT = (state_r == EBA_DESC);
   assign TX_VALID  = (state_r == EBA_SEND);
   assign TX_LAST   = TX_VALID && last_b;
   assign TX_DATA   = frame_byte(idx_r, mac_r);
   assign BOOT_DONE = (state_r == EBA_DONE);
   assign ENTRY_ADDR = entry_r;

   sends_once_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_RECV |-> ##1 !TX_VALID)
      else $error("request sent again");
   settle_wait_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $rose(state_r == EBA_SETTLE) |-> ##1 !DESC_INIT)
      else $error("settle wait cut short");
   ale_order_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_CLEAR |=> ALE_WRITE)
      else $error("lookup entry not after clear");
   ctrl_word_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_WRITE |-> SW_CFG.ctrl == EBA_SW_CTRL)
      else $error("switch control word wrong");
   bcast_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      TX_VALID && idx_r < EBA_SA_FIRST |-> TX_DATA == 8'hff)
      else $error("destination not broadcast");
   roles_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_WRITE |-> SW_CFG.an_master != {SW_CFG.boot_port,
                                         !SW_CFG.boot_port})
      else $error("boot port is negotiation master");
   done_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      BOOT_DONE |=> BOOT_DONE)
      else $error("boot completion dropped");
   no_mode_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      !is_eth && state_r == EBA_IDLE |=> state_r == EBA_IDLE)
      else $error("non ethernet mode started");
   drop_ignore_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_RECV && RX_FRAME && !frm_ok |=> $stable(seq_r))
      else $error("rejected frame counted");
   seq_step_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_RECV && frm_ok |=> seq_r == $past(seq_r) + 8'h01)
      else $error("frame sequence not advanced");
   recv_stay_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_RECV && !all_in |=> state_r == EBA_RECV)
      else $error("receive loop left early");
   // stream must not move under a stalled host
   tx_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("request byte dropped while stalled");
   desc_first_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      DESC_INIT |=> TX_VALID)
      else $error("request not after descriptor setup");
   last_once_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      TX_LAST && TX_READY |=> state_r == EBA_RECV)
      else $error("request not ended after last byte");
   src_addr_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_WRITE |-> PORT0_SRC_ADDR == ALE_MAC &&
                    PORT1_SRC_ADDR == ALE_MAC)
      else $error("port source address differs");
   mac_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r != EBA_IDLE |=> $stable(mac_r))
      else $error("device mac changed while booting");
   pll_cfg_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_SERDES |-> SERDES_CFG.pll == EBA_PLL_CFG)
      else $error("pll config wrong");
   tx_cfg_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_SERDES |-> SERDES_CFG.tx == EBA_TX_CFG)
      else $error("serializer config wrong");
   rx_cfg_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_SERDES |-> SERDES_CFG.rx == EBA_RX_CFG)
      else $error("deserializer config wrong");
   sample_div_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_SERDES |-> SERDES_CFG.sample_div == EBA_SER_DIV)
      else $error("sample divider wrong");
   fwd_all_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_WRITE |-> SW_CFG.port_fwd == 3'b111 && SW_CFG.gmii_en == 2'b11)
      else $error("ports not all forwarding");
   boot_port_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_WRITE |-> SW_CFG.fwd_ports == ~{SW_CFG.boot_port,
                                          !SW_CFG.boot_port})
      else $error("boot port set to forward");
   dma_en_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ALE_CLEAR |-> SW_CFG.dma_tx_en && SW_CFG.dma_rx_en && SW_CFG.ale_en)
      else $error("dma or lookup not enabled");
   idle_quiet_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      state_r == EBA_IDLE |-> !TX_VALID && SERDES_CFG == '0)
      else $error("idle block drives setup");
   // one write at a time: no new address while answer pending
   wr_busy_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      S_BVALID |-> !S_AWREADY && !S_WREADY)
      else $error("write taken while response pending");
   bresp_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      S_BVALID && !S_BREADY |=> S_BVALID)
      else $error("write response withdrawn");
   rdata_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
      S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
      else $error("read data withdrawn");
   take_c: cover property (@(posedge MCLK) state_r == EBA_RECV && frm_ok);
   stall_c: cover property (@(posedge MCLK) TX_VALID && !TX_READY);
   send_c: cover property (@(posedge MCLK) TX_LAST && TX_READY);
   done_c: cover property (@(posedge MCLK) $rose(BOOT_DONE));
   drop_c: cover property (@(posedge MCLK) RX_FRAME && !frm_ok);
endmodule

// ---- eba_pkg.sv ----
// package for the ethernet boot announcer: constants and carrier types
package eba_pkg;
   // boot-mode codes
   localparam logic [3:0] EBA_MODE_ONLY  = 4'h8;
   localparam logic [3:0] EBA_MODE_PORT0 = 4'h9;
   localparam logic [3:0] EBA_MODE_PORT1 = 4'ha;
   // configuration words
   localparam logic [31:0] EBA_SW_CTRL   = 32'h000000e0;
   localparam logic [31:0] EBA_PLL_CFG   = 32'h00000013;
   localparam logic [31:0] EBA_TX_CFG    = 32'h00000b21;
   localparam logic [31:0] EBA_RX_CFG    = 32'h00089121;
   localparam logic [1:0]  EBA_SER_DIV   = 2'h3;
   // settle wait: 25 ms figured at the 20 MHz block clock
   localparam int EBA_WAIT_MS    = 25;
   localparam int EBA_CPU_MHZ    = 500;
   localparam int EBA_CLK_MHZ    = 20;
   localparam int EBA_WAIT_CYC   = EBA_WAIT_MS * 1000 * EBA_CLK_MHZ;
   // request frame layout
   localparam int EBA_FRAME_LEN  = 342;
   localparam logic [8:0] EBA_SA_FIRST  = 9'h006;
   localparam logic [8:0] EBA_SA_LAST   = 9'h00b;
   localparam logic [8:0] EBA_CHA_FIRST = 9'h046;
   localparam logic [8:0] EBA_CHA_LAST  = 9'h04b;
   localparam logic [15:0] EBA_BT_MAGIC = 16'h544b;
   localparam logic [7:0]  EBA_BT_OP    = 8'h01;
   // register offsets
   localparam logic [7:0] EBA_REG_CTRL   = 8'h00;
   localparam logic [7:0] EBA_REG_STAT   = 8'h04;
   localparam logic [7:0] EBA_REG_MACLO  = 8'h08;
   localparam logic [7:0] EBA_REG_MACHI  = 8'h0c;
   localparam logic [7:0] EBA_REG_ENTRY  = 8'h10;
   localparam logic [7:0] EBA_REG_NFRM   = 8'h14;
   localparam logic [1:0] EBA_RESP_OK    = 2'h0;
   localparam logic [1:0] EBA_RESP_ERR   = 2'h2;
   typedef enum {
      EBA_IDLE, EBA_SERDES, EBA_SWITCH, EBA_ALE, EBA_SETTLE, EBA_DESC,
      EBA_SEND, EBA_RECV, EBA_DONE
   } eba_state_t;
   // switch setup bundle
   typedef struct packed {
      logic [31:0] ctrl;
      logic        boot_port;
      logic [1:0]  fwd_ports;
      logic [2:0]  port_fwd;
      logic [1:0]  gmii_en;
      logic [1:0]  an_master;
      logic        dma_tx_en;
      logic        dma_rx_en;
      logic        ale_en;
   } eba_sw_cfg_t;
   typedef struct packed {
      logic [31:0] pll;
      logic [31:0] tx;
      logic [31:0] rx;
      logic [1:0]  sample_div;
   } eba_serdes_cfg_t;
endpackage

// ---- eba_host.sv ----
// boot host model: takes the request frame, answers with boot-table frames
`timescale 1ns/1ns
module eba_host
   import eba_pkg::*;
(
   // clock, reset, pacing
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   // request stream
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   input  wire logic        tx_last,
   output logic             tx_ready,
   // frame verdicts: good, magic, opcode, sequence
   output logic             rx_frame,
   output logic [32:0]      rx_hdr,
   output int               n_sent
);
   logic [7:0]  frm [0:511];
   logic [32:0] tbl [0:5];
   logic [2:0]  cnt;
   int          n_rx;
   int          n_last;
   // a slow host takes one byte in four
   assign tx_ready = !slow || cnt[1:0] == 2'h0;
   initial begin
      // sequence starts at 0; bad frames mixed in
      tbl[0] = {1'b1, EBA_BT_MAGIC, EBA_BT_OP, 8'h00};
      tbl[1] = {1'b1, 16'h544a, EBA_BT_OP, 8'h01};
      tbl[2] = {1'b0, EBA_BT_MAGIC, EBA_BT_OP, 8'h01};
      tbl[3] = {1'b1, EBA_BT_MAGIC, EBA_BT_OP, 8'h01};
      tbl[4] = {1'b1, EBA_BT_MAGIC, 8'h02, 8'h02};
      tbl[5] = {1'b1, EBA_BT_MAGIC, EBA_BT_OP, 8'h02};
   end
   always_ff @(posedge clk) begin
      cnt <= cnt + 3'h1;
      rx_frame <= 1'b0;
      // idle fields toggle so no stale header looks valid
      rx_hdr <= ~rx_hdr;
      if (rst) begin
         cnt <= 3'h0;
         rx_hdr <= '0;
         n_rx <= 0;
         n_last <= 0;
         n_sent <= 0;
      end else begin
         if (tx_valid && tx_ready) begin
            frm[n_rx[8:0]] <= tx_data;
            n_rx <= n_rx + 1;
            n_last <= n_last + int'(tx_last);
         end
         // table split over frames, one every eight cycles
         if (n_last > 0 && n_sent < 6 && cnt == 3'h7) begin
            rx_hdr <= tbl[n_sent];
            rx_frame <= 1'b1;
            n_sent <= n_sent + 1;
         end
      end
   end
endmodule

// ---- ethernet_boot_announcer_bench.sv ----
// self-checking bench for the ethernet boot announcer
`timescale 1ns/1ns
module ethernet_boot_announcer_bench
   import eba_pkg::*;
;
   localparam int WC = 10;
   logic mclk, rst, slow, aw_v, w_v, b_r, ar_v, r_r;
   logic [3:0]  mode;
   logic [47:0] mac;
   logic [7:0]  aw_a, ar_a, tx_d;
   logic [31:0] w_d, seed;
   logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, tx_v, tx_l, tx_rdy, rx_f;
   logic [1:0]  b_resp, r_resp;
   logic [31:0] r_d, entry;
   logic [32:0] rx_hdr;
   eba_sw_cfg_t sw;
   eba_serdes_cfg_t sd;
   logic [47:0] p0, p1, amac;
   logic        a_clr, a_wr, desc, done;
   int          n_mismatch, checks_done, cyc, n_sent;
   eba_top #(.WAIT_CYC(WC)) dut (.MCLK(mclk), .SYS_RST(rst),
      .BOOT_MODE(mode), .FUSE_MAC(mac), .S_AWADDR(aw_a), .S_AWVALID(aw_v),
      .S_AWREADY(aw_rdy), .S_WDATA(w_d), .S_WSTRB(4'hf), .S_WVALID(w_v),
      .S_WREADY(w_rdy), .S_BRESP(b_resp), .S_BVALID(b_v), .S_BREADY(b_r),
      .S_ARADDR(ar_a), .S_ARVALID(ar_v), .S_ARREADY(ar_rdy), .S_RDATA(r_d),
      .S_RRESP(r_resp), .S_RVALID(r_v), .S_RREADY(r_r), .SW_CFG(sw),
      .SERDES_CFG(sd), .PORT0_SRC_ADDR(p0), .PORT1_SRC_ADDR(p1),
      .ALE_CLEAR(a_clr), .ALE_WRITE(a_wr), .ALE_MAC(amac), .DESC_INIT(desc),
      .TX_DATA(tx_d), .TX_VALID(tx_v), .TX_LAST(tx_l), .TX_READY(tx_rdy),
      .RX_FRAME(rx_f), .RX_GOOD(rx_hdr[32]), .RX_MAGIC(rx_hdr[31:16]),
      .RX_OPCODE(rx_hdr[15:8]), .RX_SEQ(rx_hdr[7:0]), .BOOT_DONE(done),
      .ENTRY_ADDR(entry));
   eba_host host (.clk(mclk), .rst(rst), .slow(slow), .tx_data(tx_d),
      .tx_valid(tx_v), .tx_last(tx_l), .tx_ready(tx_rdy), .rx_frame(rx_f),
      .rx_hdr(rx_hdr), .n_sent(n_sent));
   always #25 mclk = ~mclk;
   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      // whole run needs well under this many cycles
      if (cyc == 30000) begin
         n_mismatch++;
         test_done;
      end
   end
   task automatic cmp(input logic [127:0] g, input logic [127:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_f(input logic g, input logic e);
      cmp({127'h0, g}, {127'h0, e});
   endtask
   function automatic logic [31:0] lfsr();
      repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // writer holds each channel until its own handshake
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge mclk);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
         @(negedge mclk);
         ta = aw_v & aw_rdy;
         tw = w_v & w_rdy;
         tb = b_v;
         r = b_resp;
         @(posedge mclk);
         if (ta === 1'b1) aw_v <= 1'b0;
         if (tw === 1'b1) w_v <= 1'b0;
      end while (tb !== 1'b1);
      b_r <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      logic ta, tr;
      @(posedge mclk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(negedge mclk);
         ta = ar_v & ar_rdy;
         tr = r_v;
         d = r_d;
         r = r_resp;
         @(posedge mclk);
         if (ta === 1'b1) ar_v <= 1'b0;
      end while (tr !== 1'b1);
      r_r <= 1'b0;
   endtask
   function automatic logic [7:0] exp_byte(input int i, input logic [47:0] m);
      if (i < 6) return 8'hff;
      if (i < 12) return m[8*(11-i) +: 8];
      if (i >= 70 && i < 76) return m[8*(75-i) +: 8];
      case (i)
         12: return 8'h08;
         14: return 8'h45;
         16, 19, 38, 42, 43, 51: return 8'h01;
         17: return 8'h48;
         22: return 8'h10;
         23: return 8'h11;
         24: return 8'ha9;
         25: return 8'ha5;
         35: return 8'h44;
         37: return 8'h09;
         39: return 8'h34;
         44: return 8'h06;
         46: return 8'h12;
         47: return 8'h34;
         48: return 8'h56;
         49: return 8'h78;
         default: return 8'h00;
      endcase
   endfunction
   task automatic boot(input logic [3:0] m);
      logic [31:0] d;
      logic [1:0]  r;
      logic        b1;
      eba_sw_cfg_t e;
      int          i;
      b1 = (m == EBA_MODE_PORT1);
      e = '{EBA_SW_CTRL, b1, b1 ? 2'h1 : 2'h2, 3'h7, 2'h3,
            b1 ? 2'h1 : 2'h2, 1'b1, 1'b1, 1'b1};
      @(posedge mclk);
      mode <= m;
      mac <= {lfsr(), lfsr()};
      slow <= seed[0];
      rst <= 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      axr(EBA_REG_NFRM, d, r);
      cmp(d, 32'h1);
      axr(8'h1c, d, r);
      cmp({r, d}, {EBA_RESP_ERR, 32'h0});
      axw(EBA_REG_NFRM, 32'h3, r);
      cmp(r, EBA_RESP_OK);
      axw(EBA_REG_CTRL, 32'h1, r);
      if (!(m inside {EBA_MODE_ONLY, EBA_MODE_PORT0, EBA_MODE_PORT1})) begin
         repeat (20) @(negedge mclk);
         cmp({sw, a_clr, tx_v, done}, '0);
         return;
      end
      for (i = 0; i < 20 && a_clr !== 1'b1; i++) @(negedge mclk);
      cmp(sw, e);
      cmp(sd, {EBA_PLL_CFG, EBA_TX_CFG, EBA_RX_CFG, 2'h3});
      cmp({p0, p1}, {mac, mac});
      @(negedge mclk);
      cmp_f(a_wr, 1'b1);
      cmp(amac, mac);
      for (i = 0; i < 100 && desc !== 1'b1; i++) @(negedge mclk);
      cmp(i, WC + 1);
      cmp_f(tx_v, 1'b0);
      for (i = 0; i < 3000 && n_sent < 5; i++) @(negedge mclk);
      repeat (4) @(negedge mclk);
      cmp_f(done, 1'b0);
      for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge mclk);
      cmp_f(done, 1'b1);
      for (i = 0; i < 342; i++)
         cmp(host.frm[i], exp_byte(i, mac));
      repeat (50) @(negedge mclk);
      cmp({host.n_rx, host.n_last}, {32'd342, 32'd1});
      axr(EBA_REG_STAT, d, r);
      cmp(d[4:3], {b1, 1'b1});
      cmp(d[15:8], 8'h03);
      axr(EBA_REG_ENTRY, d, r);
      cmp({d, entry}, {2{EBA_BT_MAGIC, EBA_BT_OP, 8'h00}});
      axr(EBA_REG_MACHI, d, r);
      cmp(d, {16'h0, mac[47:32]});
      axr(EBA_REG_MACLO, d, r);
      cmp(d, mac[31:0]);
   endtask
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      seed = 32'h89e1;
      {slow, aw_v, w_v, b_r, ar_v, r_r} = '0;
      {mode, mac, aw_a, ar_a, w_d} = '0;
      {n_mismatch, checks_done, cyc} = '0;
      boot(EBA_MODE_PORT0);
      boot(EBA_MODE_PORT1);
      boot(EBA_MODE_ONLY);
      boot(4'h3);
      test_done;
   end
endmodule
